// ===== pkg/rtcs_pkg.sv
// constants shared by the clock register coupling and trim block
`default_nettype none
package rtcs_pkg;

  // ==========================================================================
  // clock rates
  localparam int unsigned CORE_HZ = 25_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam logic [24:0] TICK_INC = 25'h000_8000;
  localparam logic [24:0] TICK_MOD = 25'h17d_7840;

  // ==========================================================================
  // register addresses on the byte-wide bus
  localparam logic [12:0] ADDR_CTRL = 13'h1ff8;
  localparam logic [12:0] ADDR_SEC = 13'h1ff9;
  localparam logic [12:0] ADDR_MIN = 13'h1ffa;
  localparam logic [12:0] ADDR_HOUR = 13'h1ffb;
  localparam logic [12:0] ADDR_DAY = 13'h1ffc;
  localparam logic [12:0] ADDR_DATE = 13'h1ffd;
  localparam logic [12:0] ADDR_MONTH = 13'h1ffe;
  localparam logic [12:0] ADDR_YEAR = 13'h1fff;

  // register indices (address bits [2:0])
  localparam int unsigned IDX_CTRL = 0;
  localparam int unsigned IDX_SEC = 1;
  localparam int unsigned IDX_DAY = 4;
  localparam int unsigned IDX_YEAR = 7;

  // ==========================================================================
  // field positions
  localparam int unsigned CTRL_LOAD_BIT = 7;
  localparam int unsigned CTRL_SNAP_BIT = 6;
  localparam int unsigned CTRL_SIGN_BIT = 5;
  localparam int unsigned CTRL_MAG_MSB = 4;
  localparam int unsigned OSC_HALT_BIT = 7;
  localparam int unsigned FREQ_TEST_BIT = 6;

  // ==========================================================================
  // reset values (oscillator halted as delivered)
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SEC_RST = 8'h80;
  localparam logic [7:0] TIME_RST = 8'h00;
  localparam logic [7:0] ONE_RST = 8'h01;

  // ==========================================================================
  // bcd ranges and valid-bit masks of the time fields
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] SEC_MASK = 8'h7f;
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] DAY_MASK = 8'h07;
  localparam logic [7:0] DATE_MASK = 8'h3f;
  localparam logic [7:0] MONTH_MASK = 8'h1f;
  localparam logic [7:0] YEAR_MASK = 8'hff;

  // ==========================================================================
  // timing counts in oscillator cycles
  localparam logic [15:0] SEC_OSC_CYC = 16'h8000;
  localparam logic [15:0] TRIM_SHORT_CYC = 16'h0080;
  localparam logic [15:0] TRIM_LONG_CYC = 16'h0100;
  localparam logic [4:0] TEST_HALF_LAST = 5'h1f;

endpackage
`default_nettype wire

// ===== logic/rtcs_tick_gen.sv
// fractional divider: one-cycle enable at the oscillator rate
`timescale 1ns/10ps
`default_nettype none
module rtcs_tick_gen #(
  parameter logic [24:0] INC = rtcs_pkg::TICK_INC,
  parameter logic [24:0] MOD = rtcs_pkg::TICK_MOD
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // enable out
  output logic o_tick
);
  logic [24:0] acc_q;
  logic [24:0] acc_d;
  logic [25:0] sum;

  // phase accumulator; jitter of one core cycle is the price of no pll
  always_comb begin
    sum = {1'b0, acc_q} + {1'b0, INC};
    if (sum >= {1'b0, MOD}) begin
      acc_d = 25'(sum - {1'b0, MOD});
      o_tick = 1'b1;
    end else begin
      acc_d = sum[24:0];
      o_tick = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q <= 25'h000_0000;
    end else begin
      acc_q <= acc_d;
    end
  end
endmodule
`default_nettype wire

// ===== logic/rtcs_bcd_cnt.sv
// one bcd time field: loadable, wraps from max back to min
`timescale 1ns/10ps
`default_nettype none
module rtcs_bcd_cnt #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_inc,
  input wire logic i_load,
  input wire logic [7:0] i_load_val,
  input wire logic [7:0] i_min,
  input wire logic [7:0] i_max,
  // state
  output logic [7:0] o_val,
  output logic o_wrap
);
  logic [7:0] val_q;
  logic [7:0] val_d;

  // load wins over counting so a transfer is never half applied
  always_comb begin
    val_d = val_q;
    o_wrap = i_inc && (val_q >= i_max);
    if (i_load) begin
      val_d = i_load_val;
    end else if (o_wrap) begin
      val_d = i_min;
    end else if (i_inc) begin
      if (val_q[3:0] >= 4'h9) begin
        val_d = {4'(val_q[7:4] + 4'h1), 4'h0};
      end else begin
        val_d = {val_q[7:4], 4'(val_q[3:0] + 4'h1)};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign o_val = val_q;
endmodule
`default_nettype wire

// ===== logic/rtcs_core.sv
// real time clock register coupling, oscillator halt, trim and test output
//
// Overview of operation
// - snapshot-halt bit set freezes visible time registers at halt moment.
// - hidden counters keep counting while visible copies are frozen.
// - visible registers refresh in one cycle; a pending refresh completes.
// - after snapshot-halt clears, refresh resumes within one second.
// - load-halt bit also freezes refresh while software writes bcd time.
// - load-halt falling copies all time registers into hidden counters.
// - seconds msb is oscillator halt; writing one stops it anytime.
// - oscillator halt bit is one out of reset.
// - clearing oscillator halt restarts oscillator within one second.
// - 32768 Hz oscillator divided down to one-second ticks.
// - trim adds or removes oscillator counts in the one-second prescaler.
// - control bits 4:0 trim magnitude, bit 5 sign, one is faster.
// - 64 minute cycle; one second per minute shortened 128 or +256.
// - adjusted minutes per cycle equal twice the trim magnitude.
// - each step shifts 256 (faster) or 512 (slower) cycles per 64 minute cycle.
// - frequency-test set and oscillator running: seconds bit 0 at 512 Hz.
// - test output rate independent of trim setting.
`timescale 1ns/10ps
`default_nettype none
module rtcs_core (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // byte-wide bus strobes (asynchronous pins)
  input wire logic I_CE1_N,
  input wire logic I_CE2,
  input wire logic I_OE_N,
  input wire logic I_WE_N,
  // address and data
  input wire logic [12:0] I_ADDR,
  input wire logic [7:0] I_DATA,
  output logic [7:0] O_DATA,
  output logic O_DATA_OE
);

  // ==========================================================================
  // pin synchroniser
  localparam int unsigned SW = 25;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  assign pin_raw = {I_CE1_N, I_CE2, I_OE_N, I_WE_N, I_ADDR, I_DATA};

  // first stage feeds only the second stage
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1_q <= 25'h160_0000; // idle strobes: deselected, oe and we high
      sync2_q <= 25'h160_0000;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic ce1_n_s;
  logic ce2_s;
  logic oe_n_s;
  logic we_n_s;
  logic [12:0] addr_s;
  logic [7:0] data_s;
  assign {ce1_n_s, ce2_s, oe_n_s, we_n_s, addr_s, data_s} = sync2_q;

  logic sel;
  logic wr_act;
  logic rd_act;
  logic in_map;
  assign sel = !ce1_n_s && ce2_s;
  assign wr_act = sel && !we_n_s;
  assign rd_act = sel && we_n_s && !oe_n_s;
  assign in_map = (addr_s[12:3] == rtcs_pkg::ADDR_CTRL[12:3]);

  // ==========================================================================
  // write capture: commit at the end of the write strobe
  logic wr_q;
  logic wr_d;
  logic [12:0] wa_q;
  logic [12:0] wa_d;
  logic [7:0] wd_q;
  logic [7:0] wd_d;
  logic commit;
  logic [2:0] widx;

  // data is latched while active so the trailing edge sees settled bits
  always_comb begin
    wr_d = wr_act;
    wa_d = wa_q;
    wd_d = wd_q;
    if (wr_act) begin
      wa_d = addr_s;
      wd_d = data_s;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wr_q <= 1'b0;
      wa_q <= 13'h0000;
      wd_q <= 8'h00;
    end else begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
    end
  end

  assign commit = wr_q && !wr_act
    && (wa_q[12:3] == rtcs_pkg::ADDR_CTRL[12:3]);
  assign widx = wa_q[2:0];

  // ==========================================================================
  // oscillator enable and hidden counters
  logic osc_tick;
  logic osc_stop_q;
  logic osc_en;

  rtcs_tick_gen u_tick (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_NRST),
    .o_tick(osc_tick)
  );

  assign osc_en = osc_tick && !osc_stop_q;

  logic [7:0] vis_q [8];
  logic [7:0] vis_d [8];
  logic [7:0] hid [8];
  logic [7:0] cnt_min [8];
  logic [7:0] cnt_max [8];
  logic [7:0] cnt_mask [8];
  logic [7:0] cnt_wrap;
  logic [7:0] cnt_inc;
  logic sec_tick;
  logic load_go_q;

  // last date of a month; leap years are bcd multiples of four
  function automatic logic [7:0] month_days(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    if (yr[4]) begin
      leap = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end else begin
      leap = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    end
    case (mon)
      8'h02: month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  // field ranges, index = address bits [2:0]
  always_comb begin
    cnt_min = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    cnt_max = '{8'h00, rtcs_pkg::SEC_MAX, rtcs_pkg::SEC_MAX,
                rtcs_pkg::HOUR_MAX, rtcs_pkg::DAY_MAX,
                month_days(hid[6], hid[7]), rtcs_pkg::MONTH_MAX,
                rtcs_pkg::YEAR_MAX};
    cnt_mask = '{8'h00, rtcs_pkg::SEC_MASK, rtcs_pkg::SEC_MASK,
                 rtcs_pkg::HOUR_MASK, rtcs_pkg::DAY_MASK,
                 rtcs_pkg::DATE_MASK, rtcs_pkg::MONTH_MASK,
                 rtcs_pkg::YEAR_MASK};
    // carry chain: day of week and date both step at midnight
    cnt_inc = {cnt_wrap[6], cnt_wrap[5], cnt_wrap[3], cnt_wrap[3],
               cnt_wrap[2], cnt_wrap[1], sec_tick, 1'b0};
  end

  assign hid[0] = 8'h00;
  assign cnt_wrap[0] = 1'b0;

  // hidden counters run regardless of the visible copies
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : g_cnt
      rtcs_bcd_cnt #(
        .RST_VAL(gi == 1 ? rtcs_pkg::TIME_RST : (gi >= 4 && gi <= 6)
                 ? rtcs_pkg::ONE_RST : rtcs_pkg::TIME_RST)
      ) u_cnt (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_NRST),
        .i_inc(cnt_inc[gi]),
        .i_load(load_go_q),
        .i_load_val(vis_q[gi] & cnt_mask[gi]),
        .i_min(cnt_min[gi]),
        .i_max(cnt_max[gi]),
        .o_val(hid[gi]),
        .o_wrap(cnt_wrap[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // prescaler with trim, and the free test divider
  logic [15:0] presc_q;
  logic [15:0] presc_d;
  logic [5:0] trim_min_q;
  logic [5:0] trim_min_d;
  logic [4:0] test_div_q;
  logic [4:0] test_div_d;
  logic test_out_q;
  logic test_out_d;
  logic [15:0] sec_len;
  logic trim_now;
  logic [4:0] trim_mag;

  assign trim_mag = vis_q[0][rtcs_pkg::CTRL_MAG_MSB:0];

  // first second of each of the first 2*mag minutes is adjusted
  always_comb begin
    trim_now = (hid[1] == 8'h00)
      && (trim_min_q < {trim_mag, 1'b0});
    if (!trim_now) begin
      sec_len = rtcs_pkg::SEC_OSC_CYC;
    end else if (vis_q[0][rtcs_pkg::CTRL_SIGN_BIT]) begin
      sec_len = rtcs_pkg::SEC_OSC_CYC - rtcs_pkg::TRIM_SHORT_CYC;
    end else begin
      sec_len = rtcs_pkg::SEC_OSC_CYC + rtcs_pkg::TRIM_LONG_CYC;
    end
    sec_tick = osc_en && (presc_q >= 16'(sec_len - 16'h0001));
    presc_d = presc_q;
    trim_min_d = trim_min_q;
    if (load_go_q) begin
      presc_d = 16'h0000;
    end else if (sec_tick) begin
      presc_d = 16'h0000;
    end else if (osc_en) begin
      presc_d = 16'(presc_q + 16'h0001);
    end
    // 6-bit count wraps by itself every 64 minutes
    if (cnt_wrap[1]) begin
      trim_min_d = 6'(trim_min_q + 6'h01);
    end
    // test divider never sees the trim, so its rate stays fixed
    test_div_d = test_div_q;
    test_out_d = test_out_q;
    if (osc_en) begin
      test_div_d = 5'(test_div_q + 5'h01);
      if (test_div_q == rtcs_pkg::TEST_HALF_LAST) begin
        test_out_d = !test_out_q;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      presc_q <= 16'h0000;
      trim_min_q <= 6'h00;
      test_div_q <= 5'h00;
      test_out_q <= 1'b0;
    end else begin
      presc_q <= presc_d;
      trim_min_q <= trim_min_d;
      test_div_q <= test_div_d;
      test_out_q <= test_out_d;
    end
  end

  // ==========================================================================
  // visible registers, control, oscillator halt and test select
  logic sec_tick_q;
  logic freq_test_bit_q;
  logic freq_test_bit_d;
  logic osc_stop_d;
  logic load_go_d;
  logic halted;

  assign halted = vis_q[0][rtcs_pkg::CTRL_SNAP_BIT]
    || vis_q[0][rtcs_pkg::CTRL_LOAD_BIT];

  always_comb begin
    vis_d = vis_q;
    osc_stop_d = osc_stop_q;
    freq_test_bit_d = freq_test_bit_q;
    load_go_d = 1'b0;
    // refresh uses the halt state from before any same-cycle write,
    // so a refresh already under way always lands whole
    if (sec_tick_q && !halted) begin
      for (int i = 1; i < 8; i++) begin
        vis_d[i] = hid[i];
      end
      vis_d[rtcs_pkg::IDX_DAY][rtcs_pkg::FREQ_TEST_BIT] = freq_test_bit_q;
    end
    // host writes only touch the copies
    if (commit) begin
      vis_d[widx] = wd_q;
      if (widx == rtcs_pkg::ADDR_SEC[2:0]) begin
        osc_stop_d = wd_q[rtcs_pkg::OSC_HALT_BIT];
      end
      if (widx == rtcs_pkg::ADDR_CTRL[2:0]
          && vis_q[0][rtcs_pkg::CTRL_LOAD_BIT]
          && !wd_q[rtcs_pkg::CTRL_LOAD_BIT]) begin
        load_go_d = 1'b1;
      end
    end
    // test select is taken only on the load transfer
    if (load_go_q) begin
      freq_test_bit_d =
        vis_q[rtcs_pkg::IDX_DAY][rtcs_pkg::FREQ_TEST_BIT];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      vis_q <= '{rtcs_pkg::CTRL_RST, rtcs_pkg::SEC_RST,
                 rtcs_pkg::TIME_RST, rtcs_pkg::TIME_RST, rtcs_pkg::ONE_RST,
                 rtcs_pkg::ONE_RST, rtcs_pkg::ONE_RST, rtcs_pkg::TIME_RST};
      osc_stop_q <= 1'b1;
      freq_test_bit_q <= 1'b0;
      load_go_q <= 1'b0;
      sec_tick_q <= 1'b0;
    end else begin
      vis_q <= vis_d;
      osc_stop_q <= osc_stop_d;
      freq_test_bit_q <= freq_test_bit_d;
      load_go_q <= load_go_d;
      sec_tick_q <= sec_tick;
    end
  end

  // ==========================================================================
  // read path; addresses outside the clock window leave the bus alone
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic roe_d;
  logic roe_q;

  // seconds bit 0 is live test output for an extended read
  always_comb begin
    rdata_d = vis_q[addr_s[2:0]];
    if (addr_s[2:0] == rtcs_pkg::ADDR_SEC[2:0]) begin
      rdata_d[rtcs_pkg::OSC_HALT_BIT] = osc_stop_q;
      if (freq_test_bit_q) begin
        rdata_d[0] = test_out_q;
      end
    end
    roe_d = rd_act && in_map;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rdata_q <= 8'h00;
      roe_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      roe_q <= roe_d;
    end
  end

  assign O_DATA = rdata_q;
  assign O_DATA_OE = roe_q;
endmodule
`default_nettype wire

// ===== testbench/rtcs_core_checker.sv
// pin-level assertions for the clock register block
`timescale 1ns/10ps
`default_nettype none
module rtcs_core_checker (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // bus pins
  input wire logic I_CE1_N,
  input wire logic I_CE2,
  input wire logic I_OE_N,
  input wire logic I_WE_N,
  input wire logic [12:0] I_ADDR,
  input wire logic [7:0] I_DATA,
  input wire logic [7:0] O_DATA,
  input wire logic O_DATA_OE
);
  logic sel, rd_ok, wr_on, hold, tog, sec7_q, sec7_d;
  logic hold_q, bit_q, seen_q, seen_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  // ==========================================================================
  // raw pin decode; pins are held far longer than the sync delay
  assign sel = !I_CE1_N && I_CE2 && I_ADDR[12:3] == 10'h3ff;
  assign rd_ok = sel && I_WE_N && !I_OE_N;
  assign wr_on = sel && !I_WE_N;
  assign hold = rd_ok && I_ADDR == rtcs_pkg::ADDR_SEC && O_DATA_OE;
  assign tog = hold && hold_q && O_DATA[0] != bit_q;
  // mirrors of written bytes and the test-toggle interval counter
  always_comb begin
    ctrl_d = ctrl_q;
    sec7_d = sec7_q;
    if (wr_on && I_ADDR == rtcs_pkg::ADDR_CTRL) begin
      ctrl_d = I_DATA;
    end
    if (wr_on && I_ADDR == rtcs_pkg::ADDR_SEC) begin
      sec7_d = I_DATA[7];
    end
    seen_d = hold && (seen_q || tog);
    cnt_d = cnt_q + {15'h0000, cnt_q != 16'hffff};
    if (tog || !hold) begin
      cnt_d = 16'h0000;
    end
  end
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_q <= rtcs_pkg::CTRL_RST;
      sec7_q <= 1'h1;
      hold_q <= 1'h0;
      bit_q <= 1'h0;
      seen_q <= 1'h0;
      cnt_q <= 16'h0000;
    end else begin
      ctrl_q <= ctrl_d;
      sec7_q <= sec7_d;
      hold_q <= hold;
      bit_q <= O_DATA[0];
      seen_q <= seen_d;
      cnt_q <= cnt_d;
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  read_oe_a: assert property (rd_ok [*4] |-> O_DATA_OE)
    else $error("read held but data pins not driven");
  oe_off_a: assert property (!rd_ok [*4] |-> !O_DATA_OE)
    else $error("data pins driven without a mapped read");
  rst_out_a: assert property ($rose(I_NRST) |-> !O_DATA_OE && O_DATA == 8'h00)
    else $error("outputs not idle after reset");
  ctrl_back_a: assert property (
    (rd_ok && I_ADDR == rtcs_pkg::ADDR_CTRL) [*4] |-> O_DATA == ctrl_q)
    else $error("control byte differs from last write");
  sec_halt_a: assert property (
    (rd_ok && I_ADDR == rtcs_pkg::ADDR_SEC) [*4] |-> O_DATA[7] == sec7_q)
    else $error("oscillator halt bit wrong");
  toggle_rate_a: assert property (
    tog && seen_q |-> cnt_q >= 16'h5f5b && cnt_q <= 16'h5f60)
    else $error("test output half period wrong");
  toggle_due_a: assert property (
    seen_q && hold && !sec7_q |-> cnt_q <= 16'h5f60)
    else $error("test output stopped toggling");
  stop_toggle_a: assert property (tog |-> !sec7_q)
    else $error("test output toggles with oscillator halted");
endmodule
bind rtcs_core rtcs_core_checker chk (.I_CORE_CLK(I_CORE_CLK),
  .I_NRST(I_NRST), .I_CE1_N(I_CE1_N), .I_CE2(I_CE2), .I_OE_N(I_OE_N),
  .I_WE_N(I_WE_N), .I_ADDR(I_ADDR), .I_DATA(I_DATA), .O_DATA(O_DATA),
  .O_DATA_OE(O_DATA_OE));
`default_nettype wire

// ===== testbench/rtcs_host.sv
// host processor model on the byte-wide bus
`timescale 1ns/10ps
`default_nettype none
module rtcs_host (
  // clock
  input wire logic i_clk,
  // read side of the data pins
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  // strobes, address and write data
  output logic o_ce1_n,
  output logic o_ce2,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [12:0] o_addr,
  output logic [7:0] o_data
);
  // idle bus at time zero
  initial begin
    o_ce1_n = 1'h1;
    o_ce2 = 1'h0;
    o_oe_n = 1'h1;
    o_we_n = 1'h1;
    o_addr = 13'h0000;
    o_data = 8'h00;
  end
  // write held 3 to 5 cycles; spacing keeps strobes idle 4 cycles
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 3 + $urandom_range(0, 2);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_data = d;
    o_ce1_n = 1'h0;
    o_ce2 = 1'h1;
    o_we_n = 1'h0;
    repeat (n) @(posedge i_clk);
    #1;
    o_ce1_n = 1'h1;
    o_ce2 = 1'h0;
    o_we_n = 1'h1;
    o_data = ~d; // released data must not look held
    repeat (4) @(posedge i_clk);
  endtask
  // extended read: selected, address steady until released
  task automatic rd_on(input logic [12:0] a);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_ce1_n = 1'h0;
    o_ce2 = 1'h1;
    o_oe_n = 1'h0;
  endtask
  task automatic rd_off;
    o_ce1_n = 1'h1;
    o_ce2 = 1'h0;
    o_oe_n = 1'h1;
    repeat (4) @(posedge i_clk);
  endtask
  // single read sampled once the output flop has settled
  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic oe);
    rd_on(a);
    repeat (5) @(posedge i_clk);
    #1;
    d = i_data;
    oe = i_data_oe;
    rd_off();
  endtask
endmodule
`default_nettype wire

// ===== testbench/rtc_register_sync_and_trim_bench.sv
// self-checking bench for the clock register coupling and trim block
`timescale 1ns/10ps
`default_nettype none
module rtc_register_sync_and_trim_bench;
  localparam int RATE = 32 * rtcs_pkg::CORE_HZ / rtcs_pkg::OSC_HZ;
  logic clk, nrst, ce1_n, ce2, oe_n, we_n, d_oe, rd_oe;
  logic [12:0] addr;
  logic [7:0] din, dout, rd_d;
  int failures, total_checks, cnt, trim;
  int model [0:7] = '{0, 'h80, 0, 0, 1, 1, 1, 0};
  // loaded bytes: osc running, day with test bit, bcd upper bounds
  int tv [0:7] = '{'h80, 0, 'h59, 'h23, 'h45, 'h31, 'h12, 'h99};
  rtcs_core dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CE1_N(ce1_n),
    .I_CE2(ce2), .I_OE_N(oe_n), .I_WE_N(we_n), .I_ADDR(addr),
    .I_DATA(din), .O_DATA(dout), .O_DATA_OE(d_oe));
  rtcs_host host (.i_clk(clk), .i_data(dout), .i_data_oe(d_oe),
    .o_ce1_n(ce1_n), .o_ce2(ce2), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_addr(addr), .o_data(din));
  // 25 MHz core clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // ==========================================================================
  // compare, access and verdict tasks
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // interval tolerance covers the fractional oscillator enable
  task automatic cmp_near(input int got, input int exp);
    total_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      failures++;
      $display("unexpected count at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bw(input int i, input int d);
    host.wr(rtcs_pkg::ADDR_CTRL + 13'(i), 8'(d));
    model[i] = d;
  endtask
  task automatic br(input int i);
    host.rd(rtcs_pkg::ADDR_CTRL + 13'(i), rd_d, rd_oe);
    cmp_byte({7'h00, rd_oe}, 8'h01);
    cmp_byte(rd_d, 8'(model[i]));
  endtask
  // cycles until data bit 0 changes, capped for a stopped output
  task automatic wait_tog(output int n);
    logic b;
    b = dout[0];
    n = 0;
    while (dout[0] === b && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog past the three waits of about 25k, 25k and 30k cycles
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // ==========================================================================
  // main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    nrst = 1'h0;
    void'($urandom(23));
    repeat (3) @(posedge clk);
    #1 nrst = 1'h1;
    for (int i = 0; i < 8; i++) br(i);
    // unmapped read is not answered, unmapped write changes nothing
    host.rd(13'h0123, rd_d, rd_oe);
    cmp_byte({7'h00, rd_oe}, 8'h00);
    host.wr(13'h0ff8, 8'h3f);
    br(0);
    // load procedure with random trim sign and magnitude
    trim = $urandom_range(0, 63);
    bw(0, tv[0]);
    for (int i = 1; i < 8; i++) bw(i, tv[i]);
    for (int i = 0; i < 8; i++) br(i);
    bw(0, trim);
    br(0);
    // held read of seconds: bit 0 half period is 32 oscillator cycles
    host.rd_on(rtcs_pkg::ADDR_SEC);
    repeat (5) @(posedge clk);
    #1;
    wait_tog(cnt);
    cmp_byte({7'h00, cnt < RATE + 3}, 8'h01);
    wait_tog(cnt);
    cmp_near(cnt, RATE);
    host.rd_off();
    // halting the oscillator freezes the test output
    bw(1, 'h80);
    host.rd_on(rtcs_pkg::ADDR_SEC);
    repeat (5) @(posedge clk);
    #1;
    wait_tog(cnt);
    cmp_near(cnt, 30000);
    host.rd_off();
    // snapshot halt is held in control without starting a load
    bw(0, trim | 'h40);
    br(0);
    br(4);
    report_and_stop();
  end
endmodule
`default_nettype wire
